// ---- test/core_model.sv ----
// processor core model: vector reads, end of service, fast acknowledge
`timescale 1ns/1ps
module core_model (
  input wire logic clk,
  input wire logic vec_rd_valid,
  input wire logic vec_rd_busy,
  input wire logic [31:0] vec_rd_data,
  output logic vec_rd,
  output logic end_of_service,
  output logic fast_ack
);
  // ---------------------------------------------------------------
  // idle levels
  // ---------------------------------------------------------------
  initial begin
    vec_rd = 1'b0;
    end_of_service = 1'b0;
    fast_ack = 1'b0;
  end
  // handler entry after lag + 1 cycles; a slow core simply waits longer
  task automatic read_vec(input int lag, output logic [31:0] d, output bit ok);
    int n;
    ok = 1'b0;
    d = 32'h0;
    repeat (lag + 1) @(negedge clk);
    // a read while busy is dropped silently, so wait up to 8 cycles for busy to clear before raising it
    for (n = 0; n < 8 && vec_rd_busy !== 1'b0; n++) @(negedge clk);
    vec_rd = 1'b1;
    @(negedge clk);
    vec_rd = 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      if (vec_rd_valid === 1'b1) begin
        ok = 1'b1;
        d = vec_rd_data;
      end else begin
        @(negedge clk);
      end
    end
  endtask : read_vec
  // one-cycle strobe: end of service, or fast acknowledge
  task automatic pulse(input bit ack);
    @(negedge clk);
    if (ack) fast_ack = 1'b1;
    else end_of_service = 1'b1;
    @(negedge clk);
    fast_ack = 1'b0;
    end_of_service = 1'b0;
  endtask : pulse
endmodule : core_model

// ---- test/vectored_priority_interrupt_ctrl_tb.sv ----
// self-checking bench of the vectored interrupt unit
`timescale 1ns/1ps
module vectored_priority_interrupt_ctrl_tb;
  logic clk, sys_rst, fast_request_input, ext_request_input, protect_en, vec_wr_en;
  logic [7:0] system_peripheral_source;
  logic [30:2] periph_irq;
  logic [31:0] src_enable, fast_force, vec_wr_data, vec_rd_data, pending_status;
  logic [63:0] src_trigger;
  logic [95:0] src_prio;
  logic [4:0] vec_wr_src, service_src;
  logic vec_rd, end_of_service, fast_ack, vec_rd_valid, vec_rd_busy;
  logic normal_interrupt_line_n, fast_interrupt_line_n;
  logic [3:0] nest_depth;
  logic [2:0] service_level;
  int fail_count, total_checks, w;
  logic [31:0] rng;
  logic [31:0] pend; // enabled pending sources expected this round
  logic [31:0] vt [32]; // expected vector per source
  vectored_interrupt_unit u_dut (.clk(clk), .sys_rst(sys_rst), .fast_request_input(fast_request_input),
    .ext_request_input(ext_request_input), .system_peripheral_source(system_peripheral_source),
    .periph_irq(periph_irq), .src_enable(src_enable), .src_trigger(src_trigger), .src_prio(src_prio),
    .fast_force(fast_force), .protect_en(protect_en), .vec_wr_en(vec_wr_en), .vec_wr_src(vec_wr_src),
    .vec_wr_data(vec_wr_data), .vec_rd(vec_rd), .end_of_service(end_of_service), .fast_ack(fast_ack),
    .vec_rd_data(vec_rd_data), .vec_rd_valid(vec_rd_valid), .vec_rd_busy(vec_rd_busy),
    .normal_interrupt_line_n(normal_interrupt_line_n), .fast_interrupt_line_n(fast_interrupt_line_n),
    .pending_status(pending_status), .nest_depth(nest_depth), .service_level(service_level),
    .service_src(service_src));
  core_model u_core (.clk(clk), .vec_rd_valid(vec_rd_valid), .vec_rd_busy(vec_rd_busy),
    .vec_rd_data(vec_rd_data), .vec_rd(vec_rd), .end_of_service(end_of_service), .fast_ack(fast_ack));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [31:0] b(input logic x);
    return {31'h0, x};
  endfunction : b
  // expected winner: highest level first, lowest number on a tie
  function automatic int pick(input logic [31:0] p);
    int r;
    r = -1;
    for (int i = 1; i < 32; i++) begin
      if (p[i] && src_enable[i] && !fast_force[i] && (r < 0 || src_prio[3*i+:3] > src_prio[3*r+:3])) r = i;
    end
    return r;
  endfunction : pick
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask : gap
  task automatic cfg(input int i, input logic [1:0] t, input logic [2:0] p, input logic en);
    src_trigger[2*i+:2] = t;
    src_prio[3*i+:3] = p;
    src_enable[i] = en;
  endtask : cfg
  // read the vector through the core model and compare
  task automatic svc(input int lag, input logic [31:0] exp);
    logic [31:0] d;
    bit ok;
    u_core.read_vec(lag, d, ok);
    chk("vec_valid", 32'h1, {31'h0, ok});
    chk("vec_data", exp, d);
    chk("vec_busy", 32'h1, b(vec_rd_busy));
  endtask : svc
  // drop every request so the next test starts clean
  task automatic quiet(input string name);
    periph_irq = '0;
    system_peripheral_source = 8'h00;
    ext_request_input = 1'b0;
    fast_request_input = 1'b0;
    src_enable = '0;
    fast_force = '0;
    protect_en = 1'b0;
    gap(4);
    chk("depth", 32'h0, {28'h0, nest_depth});
    $display("test %s done", name);
  endtask : quiet
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  // watchdog: the tests need well under 3000 cycles
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    complete_run();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    fail_count = 0;
    total_checks = 0;
    rng = 32'd49793;
    sys_rst = 1'b1;
    vec_wr_en = 1'b0;
    vec_wr_src = 5'h00;
    vec_wr_data = 32'h0;
    src_trigger = {32{2'h2}}; // all level high, so nothing pulls low in reset
    src_prio = '0;
    quiet("start");
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    chk("normal_rst", 32'h1, b(normal_interrupt_line_n));
    chk("fast_rst", 32'h1, b(fast_interrupt_line_n));
    for (int i = 0; i < 32; i++) begin
      rng = xs(rng);
      vt[i] = rng;
      vec_wr_en = 1'b1;
      vec_wr_src = i[4:0];
      vec_wr_data = rng;
      gap(1);
    end
    vec_wr_en = 1'b0;
    // masking, nesting on strictly higher level only
    cfg(5, 2'h2, 3'h3, 1'b0);
    periph_irq[5] = 1'b1;
    gap(2);
    chk("masked", 32'h1, b(normal_interrupt_line_n));
    src_enable[5] = 1'b1;
    gap(2);
    chk("unmasked", 32'h0, b(normal_interrupt_line_n));
    svc(2, vt[5]);
    cfg(9, 2'h2, 3'h3, 1'b1);
    periph_irq[9] = 1'b1;
    gap(2);
    chk("equal_lvl", 32'h1, b(normal_interrupt_line_n));
    cfg(7, 2'h2, 3'h6, 1'b1);
    periph_irq[7] = 1'b1;
    gap(2);
    chk("higher_lvl", 32'h0, b(normal_interrupt_line_n));
    svc(0, vt[7]);
    chk("nest", 32'h2, {28'h0, nest_depth});
    u_core.pulse(1'b0);
    u_core.pulse(1'b0);
    quiet("nesting");
    // tie at one level goes to the lower number
    cfg(12, 2'h2, 3'h2, 1'b1);
    cfg(4, 2'h2, 3'h2, 1'b1);
    periph_irq[12] = 1'b1;
    periph_irq[4] = 1'b1;
    svc(1, vt[4]);
    u_core.pulse(1'b0);
    quiet("tie");
    // every trigger mode; edges stay latched until the vector read
    for (int m = 0; m < 4; m++) begin
      cfg(6, m[1:0], 3'h2, 1'b1);
      periph_irq[6] = ~m[1];
      gap(3);
      if (normal_interrupt_line_n === 1'b0) begin
        svc(0, vt[6]);
        u_core.pulse(1'b0);
        gap(1);
      end
      chk("idle_line", 32'h1, b(normal_interrupt_line_n));
      periph_irq[6] = m[1];
      gap(2);
      chk("act_line", 32'h0, b(normal_interrupt_line_n));
      periph_irq[6] = ~m[1];
      gap(2);
      chk("after_line", b(~m[0]), b(normal_interrupt_line_n));
      if (m[0]) begin
        svc(0, vt[6]);
        u_core.pulse(1'b0);
      end
    end
    src_trigger = {32{2'h2}};
    quiet("triggers");
    // each system peripheral line alone raises source 1
    cfg(1, 2'h2, 3'h1, 1'b1);
    for (int s = 0; s < 8; s++) begin
      system_peripheral_source = 8'h01 << s;
      gap(2);
      chk("sys_or", 32'h0, b(normal_interrupt_line_n));
    end
    svc(0, vt[1]);
    u_core.pulse(1'b0);
    quiet("system");
    // external normal pin, through its synchroniser
    cfg(31, 2'h2, 3'h4, 1'b1);
    ext_request_input = 1'b1;
    svc(4, vt[31]);
    u_core.pulse(1'b0);
    quiet("external");
    // fast pin and fast forcing stay off the normal line
    cfg(0, 2'h2, 3'h7, 1'b1);
    fast_request_input = 1'b1;
    gap(4);
    chk("fast_pin", 32'h0, b(fast_interrupt_line_n));
    chk("fast_norm", 32'h1, b(normal_interrupt_line_n));
    fast_request_input = 1'b0;
    cfg(8, 2'h2, 3'h5, 1'b1);
    fast_force[8] = 1'b1;
    periph_irq[8] = 1'b1;
    gap(4);
    chk("forced", 32'h0, b(fast_interrupt_line_n));
    chk("forced_norm", 32'h1, b(normal_interrupt_line_n));
    u_core.pulse(1'b1);
    quiet("fast");
    // protect mode: read answers but nothing is pushed
    cfg(5, 2'h2, 3'h3, 1'b1);
    periph_irq[5] = 1'b1;
    protect_en = 1'b1;
    svc(1, vt[5]);
    chk("prot_depth", 32'h0, {28'h0, nest_depth});
    quiet("protect");
    // random levels and sources, first round with nothing pending
    for (int k = 0; k < 24; k++) begin
      rng = xs(rng);
      periph_irq = (k == 0) ? '0 : rng[30:2];
      rng = xs(rng);
      src_enable = rng & 32'h7fff_fffc;
      rng = xs(rng);
      src_prio = {rng, xs(rng), xs(~rng)};
      // forcing, both pins and protect mode drawn too; the pins stay masked here
      rng = xs(rng);
      fast_force = rng & (rng >> 7);
      fast_request_input = rng[0];
      ext_request_input = rng[1];
      protect_en = rng[2] & rng[3];
      gap(1);
      pend = {1'b0, periph_irq, 2'b00} & src_enable;
      w = pick(pend);
      chk("rand_pend", pend, pending_status);
      chk("rand_fast", b(~|(pend & fast_force)), b(fast_interrupt_line_n));
      chk("rand_line", b(w < 0), b(normal_interrupt_line_n));
      svc(k % 3, (w < 0) ? vic_pkg::SPURIOUS_VEC_RST : vt[w]);
      chk("rand_depth", (w < 0 || protect_en) ? 32'h0 : 32'h1, {28'h0, nest_depth});
      if (w >= 0 && !protect_en) begin
        chk("rand_src", w, {27'h0, service_src});
        chk("rand_lvl", {29'h0, src_prio[3*w+:3]}, {29'h0, service_level});
        u_core.pulse(1'b0);
      end
    end
    quiet("random");
    complete_run();
  end
endmodule : vectored_priority_interrupt_ctrl_tb

// ---- verilog/arb_if.sv ----
// request and winner signals between the unit and its priority picker
`timescale 1ns/1ps
interface arb_if;
  logic [vic_pkg::SRC_COUNT-1:0] req; // eligible normal requests
  logic [vic_pkg::SRC_COUNT*vic_pkg::PRIO_W-1:0] prio; // level per source
  logic valid; // some request present
  logic [vic_pkg::SRC_W-1:0] src; // winning source
  logic [vic_pkg::PRIO_W-1:0] level; // winning level
  modport client (output req, output prio, input valid, input src, input level);
  modport picker (input req, input prio, output valid, output src, output level);
endinterface : arb_if

// ---- verilog/priority_pick.sv ----
// combinational eight-level priority picker
`timescale 1ns/1ps
module priority_pick (
  arb_if.picker arb
);
  // ---------------------------------------------------------------
  // pick highest level, lowest number on a tie
  // ---------------------------------------------------------------
  // scanning downward with >= lets a lower number replace an equal level
  always_comb begin
    arb.valid = 1'b0;
    arb.src = '0;
    arb.level = '0;
    for (int i = vic_pkg::SRC_COUNT - 1; i >= 0; i--) begin
      if (arb.req[i] && (!arb.valid || arb.prio[i*vic_pkg::PRIO_W +: vic_pkg::PRIO_W] >= arb.level)) begin
        arb.valid = 1'b1; // [RULE_06]
        arb.src = vic_pkg::SRC_W'(i); // [RULE_13]
        arb.level = arb.prio[i*vic_pkg::PRIO_W +: vic_pkg::PRIO_W];
      end
    end
  end
endmodule : priority_pick

// ---- verilog/vector_store.sv ----
// per-source vector memory with registered read
`timescale 1ns/1ps
module vector_store #(
  parameter int unsigned WIDTH = vic_pkg::VEC_W,
  parameter int unsigned DEPTH = vic_pkg::SRC_COUNT,
  parameter int unsigned AW = vic_pkg::SRC_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // no reset on the array: software loads every vector before use
  logic [WIDTH-1:0] mem [DEPTH];

  // write port, one word per cycle
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read every cycle; data appears one edge after the address
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr]; // [RULE_08]
    end
  end
endmodule : vector_store

// ---- verilog/vectored_interrupt_unit.sv ----
// vectored nested-priority interrupt unit driving the processor lines
`timescale 1ns/1ps
module vectored_interrupt_unit #(
  parameter logic [31:0] SPURIOUS_VEC = vic_pkg::SPURIOUS_VEC_RST
) (
  input wire logic clk,
  input wire logic sys_rst,
  // sources
  input wire logic fast_request_input,
  input wire logic ext_request_input,
  input wire logic [vic_pkg::SYS_LINES-1:0] system_peripheral_source,
  input wire logic [vic_pkg::SRC_COUNT-2:2] periph_irq,
  // configuration
  input wire logic [vic_pkg::SRC_COUNT-1:0] src_enable,
  input wire logic [2*vic_pkg::SRC_COUNT-1:0] src_trigger,
  input wire logic [vic_pkg::SRC_COUNT*vic_pkg::PRIO_W-1:0] src_prio,
  input wire logic [vic_pkg::SRC_COUNT-1:0] fast_force,
  input wire logic protect_en,
  // vector loading
  input wire logic vec_wr_en,
  input wire logic [vic_pkg::SRC_W-1:0] vec_wr_src,
  input wire logic [vic_pkg::VEC_W-1:0] vec_wr_data,
  // processor side
  input wire logic vec_rd,
  input wire logic end_of_service,
  input wire logic fast_ack,
  output logic [vic_pkg::VEC_W-1:0] vec_rd_data,
  output logic vec_rd_valid,
  output logic vec_rd_busy,
  output logic normal_interrupt_line_n,
  output logic fast_interrupt_line_n,
  // status
  output logic [vic_pkg::SRC_COUNT-1:0] pending_status,
  output logic [vic_pkg::SP_W-1:0] nest_depth,
  output logic [vic_pkg::PRIO_W-1:0] service_level,
  output logic [vic_pkg::SRC_W-1:0] service_src
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] pin_sync1; // first stage for the two pins
    logic [1:0] pin_sync2; // second stage, safe to read
    logic [vic_pkg::SRC_COUNT-1:0] raw_prev; // last source levels
    logic [vic_pkg::SRC_COUNT-1:0] edge_pend; // latched edges
    logic [vic_pkg::SRC_COUNT-1:0] status; // registered pending view
    logic [vic_pkg::SP_W-1:0] sp; // nesting depth
    logic [vic_pkg::STACK_DEPTH*vic_pkg::ENTRY_W-1:0] stack; // top at low byte
    vic_pkg::rd_state_t rd_state; // vector read pipe
    logic spur; // read found nothing
    logic [vic_pkg::VEC_W-1:0] vec_out; // vector answer
    logic vec_valid; // answer strobe
  } state_t;

  state_t state_reg; // registered state
  state_t state_next; // next state
  logic [vic_pkg::SRC_COUNT-1:0] raw; // source levels after sync
  logic [vic_pkg::SRC_COUNT-1:0] active; // pending and enabled
  logic [vic_pkg::SRC_COUNT-1:0] fast_route; // sources owned by fast line
  logic [vic_pkg::PRIO_W-1:0] top_level; // level in service
  logic normal_req; // normal line wanted
  logic fast_req; // fast line wanted
  logic take_read; // vector read accepted
  logic [vic_pkg::VEC_W-1:0] mem_data; // vector from memory
  arb_if arb (); // link to the picker

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // memory holding one vector per source
  vector_store #(
    .WIDTH(vic_pkg::VEC_W),
    .DEPTH(vic_pkg::SRC_COUNT),
    .AW(vic_pkg::SRC_W)
  ) u_vectors (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(vec_wr_en),
    .wr_addr(vec_wr_src),
    .wr_data(vec_wr_data),
    .rd_addr(arb.src),
    .rd_data(mem_data)
  );

  // eight-level picker over normal sources
  priority_pick u_pick (
    .arb(arb)
  );

  // ---------------------------------------------------------------
  // source collection
  // ---------------------------------------------------------------
  // pins come through the synchroniser; peripherals share our clock
  always_comb begin
    raw = '0;
    raw[vic_pkg::SRC_FAST] = state_reg.pin_sync2[0]; // [RULE_02]
    raw[vic_pkg::SRC_SYS] = |system_peripheral_source; // [RULE_03] [RULE_12]
    raw[vic_pkg::SRC_COUNT-2:2] = periph_irq;
    raw[vic_pkg::SRC_EXT] = state_reg.pin_sync2[1]; // [RULE_04]
  end

  // trigger evaluation per source
  always_comb begin
    active = '0;
    for (int i = 0; i < vic_pkg::SRC_COUNT; i++) begin
      unique case (vic_pkg::trig_t'(src_trigger[2*i +: 2]))
        vic_pkg::TRIG_LEVEL_LOW: active[i] = ~raw[i]; // [RULE_05]
        vic_pkg::TRIG_LEVEL_HIGH: active[i] = raw[i]; // [RULE_05]
        vic_pkg::TRIG_EDGE_FALL,
        vic_pkg::TRIG_EDGE_RISE: active[i] = state_reg.edge_pend[i]; // [RULE_05]
      endcase
    end
    active = active & src_enable; // [RULE_01]
  end

  // source 0 and every forced source belong to the fast line
  assign fast_route = fast_force | {{(vic_pkg::SRC_COUNT-1){1'b0}}, 1'b1}; // [RULE_10]
  assign arb.req = active & ~fast_route; // [RULE_06] [RULE_10]
  assign arb.prio = src_prio;

  // ---------------------------------------------------------------
  // line decisions
  // ---------------------------------------------------------------
  assign top_level = state_reg.stack[vic_pkg::PRIO_W+vic_pkg::SRC_W-1:vic_pkg::SRC_W];
  // only a strictly higher level interrupts the current service
  assign normal_req = arb.valid && ((state_reg.sp == vic_pkg::SP_RST) || (arb.level > top_level)); // [RULE_07]
  assign fast_req = |(active & fast_route); // [RULE_02] [RULE_10]
  // a read is refused while the previous answer is still in flight
  assign take_read = vec_rd && (state_reg.rd_state == vic_pkg::RD_IDLE);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [vic_pkg::SRC_COUNT-1:0] edge_set;
    logic [vic_pkg::SRC_COUNT-1:0] edge_clr;
    state_t n;
    edge_set = '0;
    edge_clr = '0;
    n = state_reg;
    // two-stage pin synchroniser
    n.pin_sync1 = {ext_request_input, fast_request_input};
    n.pin_sync2 = state_reg.pin_sync1;
    n.raw_prev = raw;
    // edge capture per selected polarity
    for (int i = 0; i < vic_pkg::SRC_COUNT; i++) begin
      if (vic_pkg::trig_t'(src_trigger[2*i +: 2]) == vic_pkg::TRIG_EDGE_RISE) begin
        edge_set[i] = raw[i] & ~state_reg.raw_prev[i]; // [RULE_05]
      end else if (vic_pkg::trig_t'(src_trigger[2*i +: 2]) == vic_pkg::TRIG_EDGE_FALL) begin
        edge_set[i] = ~raw[i] & state_reg.raw_prev[i]; // [RULE_05]
      end
    end
    // automatic acknowledge, held off entirely in protect mode
    if (!protect_en) begin // [RULE_09]
      if (take_read && arb.valid) begin
        edge_clr[arb.src] = 1'b1;
      end
      if (fast_ack) begin
        edge_clr = edge_clr | fast_route;
      end
    end
    // a new edge in the clearing cycle survives
    n.edge_pend = (state_reg.edge_pend & ~edge_clr) | edge_set;
    n.status = active;
    // nesting stack: push on read, pop on end of service
    if (take_read && arb.valid && !protect_en && (state_reg.sp < vic_pkg::SP_W'(vic_pkg::STACK_DEPTH))) begin
      n.stack = {state_reg.stack[(vic_pkg::STACK_DEPTH-1)*vic_pkg::ENTRY_W-1:0], arb.level, arb.src}; // [RULE_07]
      n.sp = state_reg.sp + vic_pkg::SP_W'(1);
    end else if (end_of_service && (state_reg.sp != vic_pkg::SP_RST)) begin
      n.stack = {{vic_pkg::ENTRY_W{1'b0}}, state_reg.stack[vic_pkg::STACK_DEPTH*vic_pkg::ENTRY_W-1:vic_pkg::ENTRY_W]};
      n.sp = state_reg.sp - vic_pkg::SP_W'(1);
    end
    // vector answer two edges after the read
    n.vec_valid = 1'b0;
    unique case (state_reg.rd_state)
      vic_pkg::RD_IDLE: begin
        if (take_read) begin
          n.spur = ~arb.valid;
          n.rd_state = vic_pkg::RD_FETCH;
        end
      end
      vic_pkg::RD_FETCH: begin
        n.vec_out = state_reg.spur ? SPURIOUS_VEC : mem_data; // [RULE_08]
        n.vec_valid = 1'b1;
        n.rd_state = vic_pkg::RD_DRIVE;
      end
      vic_pkg::RD_DRIVE: begin
        n.rd_state = vic_pkg::RD_IDLE;
      end
      default: begin
        n.rd_state = vic_pkg::RD_IDLE;
      end
    endcase
    state_next = n;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= '{pin_sync1: 2'h0, pin_sync2: 2'h0, raw_prev: 32'h0, edge_pend: 32'h0,
                     status: 32'h0, sp: vic_pkg::SP_RST, stack: vic_pkg::STACK_RST,
                     rd_state: vic_pkg::RD_IDLE, spur: 1'b0, vec_out: vic_pkg::SPURIOUS_VEC_RST,
                     vec_valid: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // both processor lines are active low and driven only here
  assign normal_interrupt_line_n = ~normal_req; // [RULE_11]
  assign fast_interrupt_line_n = ~fast_req; // [RULE_11]
  assign vec_rd_data = state_reg.vec_out;
  assign vec_rd_valid = state_reg.vec_valid;
  assign vec_rd_busy = (state_reg.rd_state != vic_pkg::RD_IDLE);
  assign pending_status = state_reg.status;
  assign nest_depth = state_reg.sp;
  assign service_level = top_level;
  assign service_src = state_reg.stack[vic_pkg::SRC_W-1:0];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_MASK: assert property (arb.valid |-> src_enable[arb.src]) // [RULE_01]
    else $error("masked source won arbitration");
  AST_FAST_SRC0: assert property (src_enable[0] && (vic_pkg::trig_t'(src_trigger[1:0]) == vic_pkg::TRIG_LEVEL_HIGH)
    && $past(fast_request_input, 2) && $past(fast_request_input, 3) |-> !fast_interrupt_line_n) // [RULE_02]
    else $error("fast input did not reach the fast line");
  AST_SYS_OR: assert property (src_enable[1] && (vic_pkg::trig_t'(src_trigger[3:2]) == vic_pkg::TRIG_LEVEL_HIGH)
    && (|system_peripheral_source) |=> pending_status[1]) // [RULE_03]
    else $error("system source not pending");
  AST_NORMAL_SRC: assert property (!normal_interrupt_line_n |-> arb.valid && (arb.src != vic_pkg::SRC_FAST)) // [RULE_06]
    else $error("normal line without a normal winner");
  AST_NEST_UP: assert property ((state_reg.sp != 4'h0) && arb.valid && (arb.level > top_level)
    |-> !normal_interrupt_line_n) // [RULE_07]
    else $error("higher level blocked during service");
  AST_NEST_HOLD: assert property ((state_reg.sp != 4'h0) && (arb.level <= top_level) |-> normal_interrupt_line_n) // [RULE_07]
    else $error("equal or lower level nested");
  AST_PUSH: assert property (take_read && arb.valid && !protect_en && (state_reg.sp < 4'h8)
    |=> (state_reg.sp == $past(state_reg.sp) + 4'h1) && (service_src == $past(arb.src))) // [RULE_07]
    else $error("service entry not pushed");
  AST_VEC_TIME: assert property (take_read |-> !vec_rd_valid ##1 !vec_rd_valid ##1 vec_rd_valid ##1 !vec_rd_valid) // [RULE_08]
    else $error("vector answer not on second edge");
  AST_PROTECT: assert property (vec_rd && protect_en && !end_of_service |=> $stable(state_reg.sp)) // [RULE_09]
    else $error("protect mode read changed nesting");
  AST_FORCE: assert property (arb.valid |-> !fast_force[arb.src]) // [RULE_10]
    else $error("forced source reached normal arbitration");

  COV_NEST2: cover property (state_reg.sp == 4'h2);
  COV_PROTECT_READ: cover property (take_read && protect_en && arb.valid);
  COV_FORCED_FAST: cover property (!fast_interrupt_line_n && !active[0]);
  COV_SPURIOUS: cover property (take_read && !arb.valid);
endmodule : vectored_interrupt_unit

// ---- verilog/vic_pkg.sv ----
// shared constants and types of the vectored interrupt unit
// Contract
// RULE_01: thirty-two sources, each maskable with own vector
// RULE_02: source 0 is the fast external input
// RULE_03: source 1 ORs the system peripheral requests
// RULE_04: source 31 is external normal request, ungated
// RULE_05: per-source edge or level, either polarity
// RULE_06: eight-level priority over sources 1 to 31
// RULE_07: strictly higher level may nest over service
// RULE_08: vector read returns serviced source's vector
// RULE_09: protect mode suppresses vector read side effects
// RULE_10: fast forcing steers normal sources to fast
// RULE_11: unit alone drives both processor interrupt lines
// RULE_12: system source never clock gated, internal only
// RULE_13: equal level ties go to lowest number
package vic_pkg;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned SRC_COUNT = 32; // number of sources
  localparam int unsigned SRC_W = 5; // source number width
  localparam int unsigned PRIO_W = 3; // eight priority levels
  localparam int unsigned VEC_W = 32; // vector width
  localparam int unsigned STACK_DEPTH = 8; // one slot per level
  localparam int unsigned SP_W = 4; // stack pointer width
  localparam int unsigned ENTRY_W = 8; // level plus source number
  localparam int unsigned SYS_LINES = 8; // system peripheral requests
  // ---------------------------------------------------------------
  // fixed source numbers
  // ---------------------------------------------------------------
  localparam logic [4:0] SRC_FAST = 5'h00; // fast external input
  localparam logic [4:0] SRC_SYS = 5'h01; // system peripherals
  localparam logic [4:0] SRC_EXT = 5'h1f; // external normal request
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] SPURIOUS_VEC_RST = 32'h0000_0000; // answer when nothing pends
  localparam logic [3:0] SP_RST = 4'h0; // stack empty
  localparam logic [63:0] STACK_RST = 64'h0; // stack contents
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  // trigger selection, two bits per source
  typedef enum logic [1:0] {
    TRIG_LEVEL_LOW = 2'h0,
    TRIG_EDGE_FALL = 2'h1,
    TRIG_LEVEL_HIGH = 2'h2,
    TRIG_EDGE_RISE = 2'h3
  } trig_t;
  // vector read pipeline
  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_FETCH = 2'h1,
    RD_DRIVE = 2'h2
  } rd_state_t;
endpackage : vic_pkg
